// ### core/acs_pkg.sv
// Shared constants and types for the serial conversion link.
package acs_pkg;
  localparam int CTRL_BITS = 8;
  localparam int RES_BITS = 16;
  localparam int VAL_BITS = 10;
  localparam int EXTRA_BITS = 2;
  localparam int TRAIL_BITS = 4;
  localparam int OPT_BITS = 5;
  localparam int WORD_BITS = VAL_BITS + EXTRA_BITS;
  localparam int START_POS = 7;
  localparam int PM_HI_POS = 1;
  localparam int PM_LO_POS = 0;
  localparam int OPT_LSB = 2;
  localparam int FIFO_DEPTH = 2;
  localparam int HALF_CYCLES_DEF = 4;
  localparam int WAIT_MAX_DEF = 8;
  localparam logic [4:0] CNT_CTRL_LAST = 5'h07;
  localparam logic [4:0] CNT_RES_LAST = 5'h0F;
  localparam logic [4:0] CNT_RES_FULL = 5'h10;
  localparam logic [1:0] FIFO_FULL = 2'h2;

  typedef enum logic [1:0] {
    ACS_DEV_IDLE = 2'b00,
    ACS_DEV_CTRL = 2'b01,
    ACS_DEV_READ = 2'b10
  } acs_dev_st_t;

  typedef enum logic [2:0] {
    ACS_HST_IDLE = 3'b000,
    ACS_HST_SEND = 3'b001,
    ACS_HST_WAIT = 3'b010,
    ACS_HST_READ = 3'b011,
    ACS_HST_DONE = 3'b100
  } acs_hst_st_t;
endpackage : acs_pkg

// ### core/acs_link_if.sv
// Serial link between the converter and its host.
`timescale 1ns/1ps
interface acs_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic conversion_strobe;
  logic dout;
  logic dout_oe;

  modport dev (
    input sclk,
    input cs_n,
    input din,
    output conversion_strobe,
    output dout,
    output dout_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output din,
    input conversion_strobe,
    input dout,
    input dout_oe
  );
endinterface : acs_link_if

// ### core/acs_host.sv
// Host end: makes the serial clock, sends the control byte, reads results.
// Summary of operation
// - One clock drives converter and host receive
// - Chip select low before shifting control bits
// - Control byte starts with 1, ends with the two power bits
// - Strobe falling edge marks result ready
// - Capture one bit on sixteen rising edges
// - Ten plus two bits, four trailing discarded
// - Chip select returns high after readout
// - First one bit is the start bit
// - Power bits both one keep full power
`timescale 1ns/1ps
module acs_host
  import acs_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_CYCLES_DEF,
  parameter int WAIT_MAX = WAIT_MAX_DEF
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [OPT_BITS-1:0] opts_i,
  input wire logic power_mode_high_bit_i,
  input wire logic power_mode_low_bit_i,
  output logic busy_o,
  output logic timeout_o,
  output logic [WORD_BITS-1:0] res_data_o,
  output logic res_valid_o,
  input wire logic res_ready_i,
  acs_link_if.host link
);
  typedef struct packed {
    acs_hst_st_t st;
    logic [7:0] hc;
    logic sclk;
    logic cs_n;
    logic din;
    logic [4:0] bits;
    logic [CTRL_BITS-1:0] ctrl;
    logic [RES_BITS-1:0] rx;
    logic [7:0] wait_c;
    logic tmo;
    logic dsync1;
    logic dsync2;
    logic ssync1;
    logic ssync2;
    logic seen;
    logic [FIFO_DEPTH-1:0][WORD_BITS-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } acs_hst_state_t;

  localparam logic [7:0] HC_LAST = 8'(HALF_CYCLES - 1);
  localparam logic [7:0] WAIT_LAST = 8'(WAIT_MAX - 1);

  acs_hst_state_t q, d;
  logic run, edge_now, rise, fall, push, pop;

  always_comb begin
    d = q;
    d.tmo = 1'b0;
    d.dsync1 = link.dout & link.dout_oe;
    d.dsync2 = q.dsync1;
    d.ssync1 = link.conversion_strobe;
    d.ssync2 = q.ssync1;
    push = 1'b0;
    pop = res_ready_i && (q.cnt != 2'h0);
    run = (q.st != ACS_HST_IDLE);
    edge_now = run && (q.hc == HC_LAST);
    rise = edge_now && !q.sclk;
    fall = edge_now && q.sclk;
    d.hc = (run && !edge_now) ? q.hc + 8'h01 : 8'h00;
    if (edge_now) begin
      d.sclk = ~q.sclk;
    end
    unique case (q.st)
      ACS_HST_IDLE: begin
        if (start_i && (q.cnt != FIFO_FULL)) begin
          d.cs_n = 1'b0;
          d.ctrl = {1'b1, opts_i, power_mode_high_bit_i,
                    power_mode_low_bit_i};
          d.din = 1'b1;
          d.bits = 5'h00;
          d.seen = 1'b0;
          d.sclk = 1'b0;
          d.st = ACS_HST_SEND;
        end
      end
      ACS_HST_SEND: begin
        // Strobe must be seen high before its fall counts
        d.seen = q.seen | q.ssync2;
        if (rise) begin
          d.bits = q.bits + 5'h01;
          if (q.bits == CNT_CTRL_LAST) begin
            d.wait_c = 8'h00;
            d.st = ACS_HST_WAIT;
          end
        end else if (fall) begin
          d.ctrl = {q.ctrl[CTRL_BITS-2:0], 1'b0};
          d.din = q.ctrl[CTRL_BITS-2];
        end
      end
      ACS_HST_WAIT: begin
        d.seen = q.seen | q.ssync2;
        // Data line only moves while the clock is low
        if (fall) begin
          d.din = 1'b0;
        end
        if (rise) begin
          if (q.seen && !q.ssync2) begin
            d.rx = {q.rx[RES_BITS-2:0], q.dsync2};
            d.bits = 5'h01;
            d.st = ACS_HST_READ;
          end else if (q.wait_c == WAIT_LAST) begin
            d.tmo = 1'b1;
            d.st = ACS_HST_DONE;
          end else begin
            d.wait_c = q.wait_c + 8'h01;
          end
        end
      end
      ACS_HST_READ: begin
        if (rise) begin
          d.rx = {q.rx[RES_BITS-2:0], q.dsync2};
          d.bits = q.bits + 5'h01;
          if (q.bits == CNT_RES_LAST) begin
            d.st = ACS_HST_DONE;
          end
        end
      end
      ACS_HST_DONE: begin
        if (fall) begin
          d.cs_n = 1'b1;
          d.st = ACS_HST_IDLE;
          push = (q.bits == CNT_RES_FULL);
        end
      end
      default: begin
        d.st = ACS_HST_IDLE;
        d.cs_n = 1'b1;
      end
    endcase
    // Trailing bits dropped, value and extra bits kept
    if (push) begin
      d.mem[q.wp] = q.rx[RES_BITS-1:TRAIL_BITS];
      d.wp = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.st <= ACS_HST_IDLE;
      q.cs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.din = q.din;
  assign busy_o = (q.st != ACS_HST_IDLE);
  assign timeout_o = q.tmo;
  assign res_data_o = q.mem[q.rp];
  assign res_valid_o = (q.cnt != 2'h0);
endmodule : acs_host

// ### core/acs_dev.sv
// Converter end: takes the control byte and shifts out the result.
`timescale 1ns/1ps
module acs_dev
  import acs_pkg::*;
(
  acs_link_if.dev link,
  input wire logic reset_i,
  input wire logic [VAL_BITS-1:0] sample_i,
  output logic full_power_o,
  output logic converting_o,
  output logic [OPT_BITS-1:0] opts_o,
  output logic power_mode_high_bit_o,
  output logic power_mode_low_bit_o
);
  typedef struct packed {
    acs_dev_st_t st;
    logic [4:0] cnt;
    logic [CTRL_BITS-1:0] ctrl;
    logic [RES_BITS-1:0] shift;
    logic strobe;
    logic dout;
    logic full_power;
    logic [OPT_BITS-1:0] opts;
    logic pm_hi;
    logic pm_lo;
    logic [VAL_BITS-1:0] smp1;
    logic [VAL_BITS-1:0] smp2;
  } acs_dev_state_t;

  acs_dev_state_t q, d;
  logic [CTRL_BITS-1:0] byte_w;
  logic [RES_BITS-1:0] word_w;

  always_comb begin
    d = q;
    d.smp1 = sample_i;
    d.smp2 = q.smp1;
    byte_w = {q.ctrl[CTRL_BITS-2:0], link.din};
    word_w = {q.smp2, {EXTRA_BITS{1'b0}}, {TRAIL_BITS{1'b0}}};
    if (!link.cs_n) begin
      unique case (q.st)
        ACS_DEV_IDLE: begin
          if (link.din) begin
            d.full_power = 1'b1;
            d.ctrl = {{(CTRL_BITS-1){1'b0}}, 1'b1};
            d.cnt = 5'h01;
            d.strobe = 1'b1;
            d.st = ACS_DEV_CTRL;
          end
        end
        ACS_DEV_CTRL: begin
          d.ctrl = byte_w;
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == CNT_CTRL_LAST) begin
            d.strobe = 1'b0;
            d.dout = word_w[RES_BITS-1];
            d.shift = {word_w[RES_BITS-2:0], 1'b0};
            d.opts = byte_w[OPT_LSB +: OPT_BITS];
            d.pm_hi = byte_w[PM_HI_POS];
            d.pm_lo = byte_w[PM_LO_POS];
            d.cnt = 5'h00;
            d.st = ACS_DEV_READ;
          end
        end
        ACS_DEV_READ: begin
          d.dout = q.shift[RES_BITS-1];
          d.shift = {q.shift[RES_BITS-2:0], 1'b0};
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == CNT_RES_LAST) begin
            d.st = ACS_DEV_IDLE;
            d.full_power = q.pm_hi & q.pm_lo;
          end
        end
        default: begin
          d.st = ACS_DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link.sclk or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.st <= ACS_DEV_IDLE;
    end else begin
      q <= d;
    end
  end

  assign link.conversion_strobe = q.strobe;
  assign link.dout = q.dout;
  assign link.dout_oe = ~link.cs_n;
  assign full_power_o = q.full_power;
  assign converting_o = (q.st == ACS_DEV_READ);
  assign opts_o = q.opts;
  assign power_mode_high_bit_o = q.pm_hi;
  assign power_mode_low_bit_o = q.pm_lo;
endmodule : acs_dev

// ### testbench/acs_link_props.sv
// Concurrent checks on the serial link between host and converter.
`timescale 1ns/1ps
module acs_link_props (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic conversion_strobe,
  input wire logic dout,
  input wire logic dout_oe
);
  logic sclk_q;
  logic rise;
  logic [4:0] n_q;
  assign rise = sclk & ~sclk_q;
  // Serial clock rises seen in the current frame
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_q <= 1'b0;
      n_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      n_q <= cs_n ? 5'h00 : n_q + 5'(rise);
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_start; rise && n_q == 5'h00 |-> din && conversion_strobe;
  endproperty
  a_start: assert property (p_start)
    else $error("start bit missed");
  property p_hold; rise && n_q inside {[1:6]} |-> conversion_strobe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("strobe dropped early");
  property p_fall;
    rise && n_q == 5'h07 |-> !conversion_strobe && $past(conversion_strobe);
  endproperty
  a_fall: assert property (p_fall)
    else $error("strobe fall misplaced");
  property p_low; !cs_n && n_q >= 5'h08 |-> !conversion_strobe; endproperty
  a_low: assert property (p_low)
    else $error("strobe high in readout");
  property p_trail; rise && n_q >= 5'h11 |-> !dout; endproperty
  a_trail: assert property (p_trail) else $error("trailing bit set");
  property p_len; $rose(cs_n) |-> n_q == 5'h18; endproperty
  a_len: assert property (p_len)
    else $error("frame length wrong");
  property p_cap; n_q <= 5'h18; endproperty
  a_cap: assert property (p_cap) else $error("too many clock rises");
  property p_oe; dout_oe == !cs_n; endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_idle; cs_n |-> !sclk; endproperty
  a_idle: assert property (p_idle)
    else $error("clock runs unselected");
  property p_din; !$stable(din) |-> !sclk; endproperty
  a_din: assert property (p_din) else $error("data moved while high");
  cover property (rise && n_q == 5'h07);
  cover property (rise && n_q == 5'h17);
  cover property ($rose(cs_n));
endmodule : acs_link_props

// ### testbench/tb.sv
// Self-checking bench joining host and converter ends.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; \
  if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  import acs_pkg::*;
  logic mclk_i = 1'b0, reset_i = 1'b0, start_i = 1'b0, hi = 1'b0, lo = 1'b0;
  logic res_ready_i = 1'b0, busy_o, timeout_o, res_valid_o, full_power_o;
  logic converting_o, pm_hi_o, pm_lo_o, conv_seen = 1'b0, tmo_seen = 1'b0;
  logic [OPT_BITS-1:0] opts_i = 5'h00, opts_o;
  logic [VAL_BITS-1:0] sample_i = 10'h000;
  logic [WORD_BITS-1:0] res_data_o, q[$];
  logic [23:0] dq, cq;
  int n_fail = 0, num_checks = 0, k;
  acs_link_if link ();
  acs_host i_acs_host (.mclk_i(mclk_i), .reset_i(reset_i), .start_i(start_i),
    .opts_i(opts_i), .power_mode_high_bit_i(hi), .power_mode_low_bit_i(lo),
    .busy_o(busy_o), .timeout_o(timeout_o), .res_data_o(res_data_o),
    .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .link(link));
  acs_dev i_acs_dev (.link(link), .reset_i(reset_i), .sample_i(sample_i),
    .full_power_o(full_power_o), .converting_o(converting_o),
    .opts_o(opts_o), .power_mode_high_bit_o(pm_hi_o),
    .power_mode_low_bit_o(pm_lo_o));
  acs_link_props i_acs_link_props (.mclk_i(mclk_i), .reset_i(reset_i),
    .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din),
    .conversion_strobe(link.conversion_strobe), .dout(link.dout),
    .dout_oe(link.dout_oe));
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (converting_o === 1'b1) conv_seen = 1'b1;
    if (timeout_o === 1'b1) tmo_seen = 1'b1;
  end
  // Wire capture: din and the dout shown after the previous rise
  always @(posedge link.sclk) if (link.cs_n === 1'b0) begin
    dq = {dq[22:0], link.dout};
    cq = {cq[22:0], link.din};
  end
  function automatic logic [WORD_BITS-1:0] exp_word(input logic [9:0] v);
    return {v, {EXTRA_BITS{1'b0}}};
  endfunction : exp_word
  function automatic logic [CTRL_BITS-1:0] exp_ctrl(input logic [4:0] o,
      input logic [1:0] pm);
    return {1'b1, o, pm};
  endfunction : exp_ctrl
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic run(input logic [9:0] v, input logic [4:0] o,
      input logic [1:0] pm);
    int i;
    logic tk;
    tk = q.size() < FIFO_DEPTH;
    conv_seen = 1'b0;
    @(posedge mclk_i);
    sample_i <= v;
    opts_i <= o;
    {hi, lo} <= pm;
    start_i <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    for (i = 0; i < 2; i++) @(posedge mclk_i);
    for (i = 0; i < 3000 && busy_o !== 1'b0; i++) @(posedge mclk_i);
    if (i == 3000) begin n_fail++; finish_test(); end
    `CHK("taken", tk, conv_seen)
    if (tk) begin
      q.push_back(exp_word(v));
      `CHK("wire word", {exp_word(v), 4'h0}, dq[15:0])
      `CHK("ctrl byte", exp_ctrl(o, pm), cq[23:16])
      `CHK("opts", o, opts_o)
      `CHK("pm", pm, {pm_hi_o, pm_lo_o})
      `CHK("power", pm == 2'b11, full_power_o)
    end
    `CHK("timeout", 1'b0, tmo_seen)
  endtask : run
  task automatic drain;
    int i;
    logic [WORD_BITS-1:0] e;
    res_ready_i <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      e = q.size() > 0 ? q[0] : 'x;
      if (res_valid_o === 1'b1) begin
        `CHK("word", e, res_data_o)
        if (q.size() > 0) void'(q.pop_front());
      end
    end
    res_ready_i <= 1'b0;
    `CHK("left", 0, q.size())
  endtask : drain
  initial begin
    reset_i <= 1'b1;
    void'($urandom(9));
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    run(10'h3FF, 5'h1F, 2'b11);
    run(10'h000, 5'h00, 2'b01);
    run(10'h155, 5'h0A, 2'b10);
    drain();
    for (k = 0; k < 8; k++) begin
      run(10'($urandom), 5'($urandom), 2'(k));
      drain();
    end
    start_i <= 1'b1;
    repeat (60) @(posedge mclk_i);
    reset_i <= 1'b1;
    start_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    `CHK("reset cs_n", 1'b1, link.cs_n)
    `CHK("reset valid", 1'b0, res_valid_o)
    reset_i <= 1'b0;
    run(10'h2AA, 5'h15, 2'b11);
    drain();
    finish_test();
  end
endmodule : tb
